// ---- bad_decoder.sv ----
// Purpose: Physical address decoder of the board
// Assumes: CPU and PCI inbound requests are single-cycle strobes
// Notes: All selects appear one clock after the strobe
//
// Overview of operation
// - Decode only address bits 31 to 0
// - Reset fetch region always selects ROM
// - Onboard resources live in low 512 MB
// - Lowest 256 MB selects DRAM
// - ISA window forwards to PCI memory
// - 112 MB window to PCI memory, offset
// - 16 MB window to PCI I/O space
// - Config window; device select from high bits
// - 64 KB bridge register select
// - Three byte-writable ROM programming windows
// - Boot region follows boot source jumper
// - Fixed socket EPROM and flash regions
// - Four LED cells, leftmost lowest
// - Interrupt controller and logic revision selects
// - Board config, DRAM config, revision selects
// - Space above 512 MB forwards to PCI
// - Inbound 8 MB identity window to memory
// - Inbound 256 MB window onto memory
// - Apertures: base, mask, relocation; decoder sets space type
`timescale 1ns/1ps

module bad_decoder
  import bad_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_CPU_VALID,
  input wire logic [bad_pkg::CPU_ADDR_W-1:0] I_CPU_ADDR,
  input wire logic I_CPU_WRITE,
  input wire logic I_CPU_UNCACHED,
  input wire logic I_BOOT_SOURCE_JUMPER,
  input wire logic I_PCI_IN_VALID,
  input wire logic [31:0] I_PCI_IN_ADDR,
  output logic O_DRAM_SEL,
  output logic [bad_pkg::DRAM_AW-1:0] O_DRAM_ADDR,
  output logic O_ROM_SOCKET_SEL,
  output logic O_FLASH_SEL,
  output logic O_ROM_WRITE_EN,
  output logic [bad_pkg::ROM_AW-1:0] O_ROM_ADDR,
  output logic O_BRIDGE_REG_SEL,
  output logic [3:0] O_LED_CELL_SEL,
  output logic O_INTC_SEL,
  output logic [3:0] O_INTC_INDEX,
  output logic O_LOGIC_REV_SEL,
  output logic O_BOARD_CFG0_SEL,
  output logic O_BOARD_CFG1_SEL,
  output logic O_DRAM_CFG_SEL,
  output logic O_BOARD_REV_SEL,
  output logic O_PCI_REQ,
  output bad_pkg::bad_space_t O_PCI_SPACE,
  output logic [31:0] O_PCI_ADDR,
  output logic O_PCI_WRITE,
  output logic [bad_pkg::CFG_IDSEL_W-1:0] O_PCI_CONFIG_DEVICE_SELECT,
  output logic O_ISA_SUBTRACTIVE,
  output logic O_CACHED_PCI_ERR,
  output logic O_UNMAPPED,
  output logic O_LMEM_REQ,
  output logic [bad_pkg::DRAM_AW-1:0] O_LMEM_ADDR,
  output logic O_LMEM_ISA_DMA
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic win(input logic [31:0] x, input logic [31:0] base, input int lg);
    win = (x >> lg) == (base >> lg);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0] a;
  logic onboard;
  logic hit_dram;
  logic hit_isa;
  logic hit_pmem;
  logic hit_pio;
  logic hit_cfg;
  logic cfg_ok;
  logic hit_brg;
  logic hit_pb;
  logic hit_ps;
  logic hit_pf;
  logic hit_boot;
  logic hit_sock;
  logic hit_flash;
  logic hit_high;
  logic hit_lio;
  logic to_flash;
  logic prog_hit;
  logic pci_fwd;
  logic cached_err;
  logic any_hit;
  logic sel_sock;
  logic sel_flash;
  logic [ROM_AW-1:0] rom_off;
  logic [CFG_DEV_W-1:0] cfg_dev;
  logic [31:0] cfg_addr;
  logic [31:0] pci_addr;
  bad_space_t pci_space;
  logic [DRAM_AW-1:0] lmem_addr;
  logic lmem_hit;
  logic dram_sel_q;
  logic dram_sel_d;
  logic [DRAM_AW-1:0] dram_addr_q;
  logic sock_q;
  logic flash_q;
  logic rom_we_q;
  logic [ROM_AW-1:0] rom_addr_q;
  logic brg_q;
  logic [3:0] led_q;
  logic intc_q;
  logic [3:0] intc_idx_q;
  logic rev_q;
  logic bcfg0_q;
  logic bcfg1_q;
  logic dcfg_q;
  logic brev_q;
  logic pci_req_q;
  logic pci_req_d;
  bad_space_t pci_space_q;
  logic [31:0] pci_addr_q;
  logic pci_we_q;
  logic isa_q;
  logic cerr_q;
  logic unm_q;
  logic lmem_req_q;
  logic [DRAM_AW-1:0] lmem_addr_q;
  logic lmem_isa_q;

  bad_ap_if ap_mem();
  bad_ap_if ap_io();
  bad_ap_if in_isa();
  bad_ap_if in_all();
  bad_lio_if lio();

  // ----------------------------------------
  // Address classification
  // ----------------------------------------
  assign a = I_CPU_ADDR[31:0];
  assign onboard = win(a, ONBOARD_BASE, ONBOARD_LG);
  assign hit_dram = win(a, DRAM_BASE, DRAM_LG);
  assign hit_isa = win(a, ISA_WIN_BASE, ISA_WIN_LG);
  assign hit_pmem = a >= PCI_MEM_FIRST && a <= PCI_MEM_LAST;
  assign hit_pio = win(a, PCI_IO_BASE, PCI_IO_LG);
  assign cfg_ok = a[PCI_CFG_LG-1:CFG_DEV_LSB+CFG_DEV_W] == '0;
  assign hit_cfg = win(a, PCI_CFG_BASE, PCI_CFG_LG) && cfg_ok;
  assign hit_brg = win(a, BRIDGE_BASE, BRIDGE_LG);
  assign hit_pb = win(a, PROG_BOOT_BASE, ROM512_LG);
  assign hit_ps = win(a, PROG_SOCK_BASE, ROM512_LG);
  assign hit_pf = win(a, PROG_FLASH_BASE, FLASH_LG);
  assign hit_boot = win(a, BOOT_BASE, ROM512_LG);
  assign hit_sock = win(a, SOCK_BASE, ROM512_LG);
  assign hit_flash = win(a, FLASH_BASE, FLASH_LG);
  assign hit_high = !onboard;

  // ----------------------------------------
  // Local I/O
  // ----------------------------------------
  assign lio.addr = a;

  bad_lio_decode u_lio (
    .port(lio.lio)
  );

  assign hit_lio = (|lio.led) | lio.intc | lio.logic_rev | lio.bcfg0 | lio.bcfg1 | lio.dram_cfg | lio.board_rev;

  // ----------------------------------------
  // ROM steering
  // ----------------------------------------
  assign to_flash = I_BOOT_SOURCE_JUMPER;
  assign prog_hit = hit_pb | hit_ps | hit_pf;
  assign sel_sock = hit_sock | hit_ps | ((hit_boot | hit_pb) & !to_flash);
  assign sel_flash = hit_flash | hit_pf | ((hit_boot | hit_pb) & to_flash);
  assign rom_off = (hit_flash | hit_pf) ? a[ROM_AW-1:0] : {1'b0, a[ROM512_LG-1:0]};

  // ----------------------------------------
  // Outbound apertures
  // ----------------------------------------
  assign ap_mem.addr = a;
  assign ap_io.addr = a;

  bad_aperture #(
    .BASE(AP_MEM_BASE),
    .MASK(AP_MEM_MASK),
    .RELOC(AP_MEM_RELOC)
  ) u_ap_mem (
    .port(ap_mem.ap)
  );

  bad_aperture #(
    .BASE(AP_IO_BASE),
    .MASK(AP_IO_MASK),
    .RELOC(AP_IO_RELOC)
  ) u_ap_io (
    .port(ap_io.ap)
  );

  // ----------------------------------------
  // Config cycle address
  // ----------------------------------------
  assign cfg_dev = a[CFG_DEV_LSB+CFG_DEV_W-1:CFG_DEV_LSB];
  assign cfg_addr = (32'h0000_0001 << (CFG_IDSEL_LSB + 32'(cfg_dev))) | {21'h0, a[CFG_DEV_LSB-1:0]};

  // ----------------------------------------
  // PCI forwarding
  // ----------------------------------------
  assign pci_fwd = hit_isa | hit_pmem | hit_pio | hit_cfg | hit_high;
  assign cached_err = pci_fwd & !I_CPU_UNCACHED;

  always_comb
  begin
    pci_addr = a;
    pci_space = BAD_SP_MEM;
    if (hit_cfg)
    begin
      pci_addr = cfg_addr;
      pci_space = BAD_SP_CFG;
    end
    else if (hit_pio)
    begin
      pci_addr = ap_io.xlat;
      pci_space = BAD_SP_IO;
    end
    else if (ap_mem.hit && onboard)
    begin
      pci_addr = ap_mem.xlat;
      pci_space = BAD_SP_MEM;
    end
  end

  // ----------------------------------------
  // Unmapped detection
  // ----------------------------------------
  assign any_hit = hit_dram | pci_fwd | hit_brg | prog_hit | hit_boot | hit_sock | hit_flash | hit_lio;
  assign dram_sel_d = I_CPU_VALID & hit_dram;
  assign pci_req_d = I_CPU_VALID & pci_fwd & !cached_err;

  // ----------------------------------------
  // Inbound windows
  // ----------------------------------------
  assign in_isa.addr = I_PCI_IN_ADDR;
  assign in_all.addr = I_PCI_IN_ADDR;

  bad_aperture #(
    .BASE(IN_ISA_BASE),
    .MASK(IN_ISA_MASK),
    .RELOC(IN_ISA_LOCAL)
  ) u_in_isa (
    .port(in_isa.ap)
  );

  bad_aperture #(
    .BASE(IN_ALL_BASE),
    .MASK(IN_ALL_MASK),
    .RELOC(IN_ALL_LOCAL)
  ) u_in_all (
    .port(in_all.ap)
  );

  assign lmem_hit = in_isa.hit | in_all.hit;
  assign lmem_addr = in_isa.hit ? in_isa.xlat[DRAM_AW-1:0] : in_all.xlat[DRAM_AW-1:0];

  // ----------------------------------------
  // Memory, ROM and bridge register selects
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      dram_sel_q <= 1'b0;
      sock_q <= 1'b0;
      flash_q <= 1'b0;
      rom_we_q <= 1'b0;
      brg_q <= 1'b0;
    end
    else
    begin
      dram_sel_q <= dram_sel_d;
      sock_q <= I_CPU_VALID & sel_sock;
      flash_q <= I_CPU_VALID & sel_flash;
      rom_we_q <= I_CPU_VALID & I_CPU_WRITE & prog_hit;
      brg_q <= I_CPU_VALID & hit_brg;
    end
  end

  // ----------------------------------------
  // Local I/O selects
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      led_q <= 4'h0;
      intc_q <= 1'b0;
      rev_q <= 1'b0;
      bcfg0_q <= 1'b0;
      bcfg1_q <= 1'b0;
      dcfg_q <= 1'b0;
      brev_q <= 1'b0;
    end
    else
    begin
      led_q <= I_CPU_VALID ? lio.led : 4'h0;
      intc_q <= I_CPU_VALID & lio.intc;
      rev_q <= I_CPU_VALID & lio.logic_rev;
      bcfg0_q <= I_CPU_VALID & lio.bcfg0;
      bcfg1_q <= I_CPU_VALID & lio.bcfg1;
      dcfg_q <= I_CPU_VALID & lio.dram_cfg;
      brev_q <= I_CPU_VALID & lio.board_rev;
    end
  end

  // ----------------------------------------
  // PCI request and status
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      pci_req_q <= 1'b0;
      isa_q <= 1'b0;
      cerr_q <= 1'b0;
      unm_q <= 1'b0;
    end
    else
    begin
      pci_req_q <= pci_req_d;
      isa_q <= pci_req_d & hit_isa;
      cerr_q <= I_CPU_VALID & cached_err;
      unm_q <= I_CPU_VALID & !any_hit;
    end
  end

  // ----------------------------------------
  // Held address and attribute registers
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      dram_addr_q <= '0;
      rom_addr_q <= '0;
      intc_idx_q <= 4'h0;
      pci_addr_q <= 32'h0000_0000;
      pci_space_q <= BAD_SP_MEM;
      pci_we_q <= 1'b0;
    end
    else if (I_CPU_VALID)
    begin
      dram_addr_q <= a[DRAM_AW-1:0];
      rom_addr_q <= rom_off;
      intc_idx_q <= lio.intc_idx;
      pci_addr_q <= pci_addr;
      pci_space_q <= pci_space;
      pci_we_q <= I_CPU_WRITE;
    end
  end

  // ----------------------------------------
  // Inbound request
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      lmem_req_q <= 1'b0;
      lmem_isa_q <= 1'b0;
      lmem_addr_q <= '0;
    end
    else
    begin
      lmem_req_q <= I_PCI_IN_VALID & lmem_hit;
      lmem_isa_q <= I_PCI_IN_VALID & in_isa.hit;
      if (I_PCI_IN_VALID)
      begin
        lmem_addr_q <= lmem_addr;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_DRAM_SEL = dram_sel_q;
  assign O_DRAM_ADDR = dram_addr_q;
  assign O_ROM_SOCKET_SEL = sock_q;
  assign O_FLASH_SEL = flash_q;
  assign O_ROM_WRITE_EN = rom_we_q;
  assign O_ROM_ADDR = rom_addr_q;
  assign O_BRIDGE_REG_SEL = brg_q;
  assign O_LED_CELL_SEL = led_q;
  assign O_INTC_SEL = intc_q;
  assign O_INTC_INDEX = intc_idx_q;
  assign O_LOGIC_REV_SEL = rev_q;
  assign O_BOARD_CFG0_SEL = bcfg0_q;
  assign O_BOARD_CFG1_SEL = bcfg1_q;
  assign O_DRAM_CFG_SEL = dcfg_q;
  assign O_BOARD_REV_SEL = brev_q;
  assign O_PCI_REQ = pci_req_q;
  assign O_PCI_SPACE = pci_space_q;
  assign O_PCI_ADDR = pci_addr_q;
  assign O_PCI_WRITE = pci_we_q;
  assign O_PCI_CONFIG_DEVICE_SELECT = pci_addr_q[CFG_IDSEL_LSB+CFG_IDSEL_W-1:CFG_IDSEL_LSB];
  assign O_ISA_SUBTRACTIVE = isa_q;
  assign O_CACHED_PCI_ERR = cerr_q;
  assign O_UNMAPPED = unm_q;
  assign O_LMEM_REQ = lmem_req_q;
  assign O_LMEM_ADDR = lmem_addr_q;
  assign O_LMEM_ISA_DMA = lmem_isa_q;

endmodule

// ---- bad_pkg.sv ----
// Purpose: Shared constants and types of the board address decoder
// Assumes: Byte addresses, 32 decoded bits
// Notes: Window sizes are held as log2 of the byte count
package bad_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int CPU_ADDR_W = 36;
  localparam int DRAM_AW = 28;
  localparam int ROM_AW = 20;

  // ----------------------------------------
  // Onboard region
  // ----------------------------------------
  localparam logic [31:0] ONBOARD_BASE = 32'h0000_0000;
  localparam int ONBOARD_LG = 29;
  localparam logic [31:0] DRAM_BASE = 32'h0000_0000;
  localparam int DRAM_LG = 28;

  // ----------------------------------------
  // CPU windows that forward to PCI, and the bridge register window
  // ----------------------------------------
  localparam logic [31:0] ISA_WIN_BASE = 32'h1000_0000;
  localparam int ISA_WIN_LG = 23;
  localparam logic [31:0] PCI_MEM_FIRST = 32'h1100_0000;
  localparam logic [31:0] PCI_MEM_LAST = 32'h17ff_ffff;
  localparam logic [31:0] PCI_IO_BASE = 32'h1d00_0000;
  localparam int PCI_IO_LG = 24;
  localparam logic [31:0] PCI_CFG_BASE = 32'h1ee0_0000;
  localparam int PCI_CFG_LG = 20;
  localparam int CFG_DEV_LSB = 11;
  localparam int CFG_DEV_W = 4;
  localparam int CFG_IDSEL_LSB = 16;
  localparam int CFG_IDSEL_W = 16;
  localparam logic [31:0] BRIDGE_BASE = 32'h1ef0_0000;
  localparam int BRIDGE_LG = 16;

  // ----------------------------------------
  // Outbound apertures: base, size mask, relocation
  // ----------------------------------------
  localparam logic [31:0] AP_MEM_BASE = 32'h1000_0000;
  localparam logic [31:0] AP_MEM_MASK = 32'hf000_0000;
  localparam logic [31:0] AP_MEM_RELOC = 32'h0000_0000;
  localparam logic [31:0] AP_IO_BASE = 32'h1d00_0000;
  localparam logic [31:0] AP_IO_MASK = 32'hff00_0000;
  localparam logic [31:0] AP_IO_RELOC = 32'h0000_0000;

  // ----------------------------------------
  // Inbound windows onto local memory
  // ----------------------------------------
  localparam logic [31:0] IN_ISA_BASE = 32'h0080_0000;
  localparam logic [31:0] IN_ISA_MASK = 32'hff80_0000;
  localparam logic [31:0] IN_ISA_LOCAL = 32'h0080_0000;
  localparam logic [31:0] IN_ALL_BASE = 32'h8000_0000;
  localparam logic [31:0] IN_ALL_MASK = 32'hf000_0000;
  localparam logic [31:0] IN_ALL_LOCAL = 32'h0000_0000;

  // ----------------------------------------
  // ROM regions
  // ----------------------------------------
  localparam logic [31:0] PROG_BOOT_BASE = 32'h1f80_0000;
  localparam logic [31:0] PROG_SOCK_BASE = 32'h1f90_0000;
  localparam logic [31:0] PROG_FLASH_BASE = 32'h1fa0_0000;
  localparam logic [31:0] BOOT_BASE = 32'h1fc0_0000;
  localparam logic [31:0] SOCK_BASE = 32'h1fd0_0000;
  localparam logic [31:0] FLASH_BASE = 32'h1fe0_0000;
  localparam int ROM512_LG = 19;
  localparam int FLASH_LG = 20;

  // ----------------------------------------
  // Local I/O
  // ----------------------------------------
  localparam int LIO_STRIDE_LG = 2;
  localparam logic [31:0] LED_BASE = 32'h1ff2_0010;
  localparam int LED_CNT = 4;
  localparam logic [31:0] INTC_BASE = 32'h1ff9_0000;
  localparam int INTC_CNT = 9;
  localparam logic [31:0] LOGIC_REV_ADDR = 32'h1ff9_003c;
  localparam logic [31:0] BCFG0_ADDR = 32'h1ffa_0000;
  localparam logic [31:0] BCFG1_ADDR = 32'h1ffb_0000;
  localparam logic [31:0] DRAM_CFG_ADDR = 32'h1ffc_0000;
  localparam logic [31:0] BOARD_REV_ADDR = 32'h1ffd_0000;

  typedef enum logic [1:0] {BAD_SP_MEM, BAD_SP_IO, BAD_SP_CFG} bad_space_t;

endpackage

// ---- bad_if.sv ----
// Purpose: Carriers between the decoder and its window and local I/O blocks
// Assumes: Combinational request and answer
// Notes: None
`timescale 1ns/1ps

interface bad_ap_if;
  logic [31:0] addr;
  logic hit;
  logic [31:0] xlat;
  modport ap (input addr, output hit, output xlat);
  modport dec (output addr, input hit, input xlat);
endinterface

interface bad_lio_if;
  logic [31:0] addr;
  logic [3:0] led;
  logic intc;
  logic [3:0] intc_idx;
  logic logic_rev;
  logic bcfg0;
  logic bcfg1;
  logic dram_cfg;
  logic board_rev;
  modport lio (input addr, output led, intc, intc_idx, logic_rev, bcfg0, bcfg1, dram_cfg, board_rev);
  modport dec (output addr, input led, intc, intc_idx, logic_rev, bcfg0, bcfg1, dram_cfg, board_rev);
endinterface

// ---- bad_aperture.sv ----
// Purpose: Masked window match with base relocation
// Assumes: Mask has ones over the compared high bits
// Notes: Used for outbound apertures and inbound windows
`timescale 1ns/1ps

module bad_aperture #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] MASK = 32'hffff_0000,
  parameter logic [31:0] RELOC = 32'h0000_0000
) (
  bad_ap_if.ap port
);

  // ----------------------------------------
  // Match and relocate
  // ----------------------------------------
  assign port.hit = ((port.addr ^ BASE) & MASK) == 32'h0000_0000;
  assign port.xlat = (RELOC & MASK) | (port.addr & ~MASK);

endmodule

// ---- bad_lio_decode.sv ----
// Purpose: Local I/O register selects
// Assumes: One register per word
// Notes: Combinational
`timescale 1ns/1ps

module bad_lio_decode
  import bad_pkg::*;
(
  bad_lio_if.lio port
);

  logic [31:0] led_off;
  logic [31:0] intc_off;

  // ----------------------------------------
  // Offsets from each bank base
  // ----------------------------------------
  assign led_off = port.addr - LED_BASE;
  assign intc_off = port.addr - INTC_BASE;

  // ----------------------------------------
  // Selects
  // ----------------------------------------
  always_comb
  begin
    port.led = 4'h0;
    if (led_off < 32'(LED_CNT << LIO_STRIDE_LG) && led_off[LIO_STRIDE_LG-1:0] == '0)
    begin
      port.led[led_off[LIO_STRIDE_LG+1:LIO_STRIDE_LG]] = 1'b1;
    end
  end

  assign port.intc = intc_off < 32'(INTC_CNT << LIO_STRIDE_LG) && intc_off[LIO_STRIDE_LG-1:0] == '0;
  assign port.intc_idx = intc_off[LIO_STRIDE_LG+3:LIO_STRIDE_LG];
  assign port.logic_rev = port.addr == LOGIC_REV_ADDR;
  assign port.bcfg0 = port.addr == BCFG0_ADDR;
  assign port.bcfg1 = port.addr == BCFG1_ADDR;
  assign port.dram_cfg = port.addr == DRAM_CFG_ADDR;
  assign port.board_rev = port.addr == BOARD_REV_ADDR;

endmodule

// ---- bad_decoder_properties.sv ----
// Purpose: Port checks of the board address decoder
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by bind
`timescale 1ns/1ps

module bad_decoder_properties (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_CPU_VALID,
  input wire logic [bad_pkg::CPU_ADDR_W-1:0] I_CPU_ADDR,
  input wire logic I_CPU_UNCACHED,
  input wire logic I_BOOT_SOURCE_JUMPER,
  input wire logic I_PCI_IN_VALID,
  input wire logic [31:0] I_PCI_IN_ADDR,
  input wire logic O_DRAM_SEL,
  input wire logic [bad_pkg::DRAM_AW-1:0] O_DRAM_ADDR,
  input wire logic O_ROM_SOCKET_SEL,
  input wire logic O_FLASH_SEL,
  input wire logic O_PCI_REQ,
  input wire logic [31:0] O_PCI_ADDR,
  input wire logic O_ISA_SUBTRACTIVE,
  input wire logic O_CACHED_PCI_ERR,
  input wire logic O_UNMAPPED,
  input wire logic [3:0] O_LED_CELL_SEL,
  input wire logic O_LMEM_REQ,
  input wire logic [bad_pkg::DRAM_AW-1:0] O_LMEM_ADDR,
  input wire logic O_LMEM_ISA_DMA
);
  import bad_pkg::*;
  // ----------
  // Checks
  // ----------
  wire logic [31:0] ca = I_CPU_ADDR[31:0];
  wire logic uv = I_CPU_VALID && I_CPU_UNCACHED;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  a_dram_low_sel: assert property (
    I_CPU_VALID && ca[31:28] == 4'h0 |=> O_DRAM_SEL && O_DRAM_ADDR == $past(ca[27:0]))
    else $error("dram decode wrong");
  a_boot_rom_sel: assert property (
    I_CPU_VALID && ca[31:19] == 13'h03f8 |=> O_FLASH_SEL == $past(I_BOOT_SOURCE_JUMPER)
    && O_ROM_SOCKET_SEL != $past(I_BOOT_SOURCE_JUMPER))
    else $error("boot region select wrong");
  a_isa_subtr: assert property (
    uv && ca[31:23] == 9'h020 |=> O_PCI_REQ && O_ISA_SUBTRACTIVE)
    else $error("isa window not forwarded");
  a_mem_offset: assert property (
    uv && ca >= 32'h1100_0000 && ca <= 32'h17ff_ffff |=> O_PCI_REQ && O_PCI_ADDR == $past(ca) - 32'h1000_0000)
    else $error("pci memory offset wrong");
  a_high_ident: assert property (
    uv && ca[31:29] != 3'h0 |=> O_PCI_REQ && O_PCI_ADDR == $past(ca))
    else $error("high window wrong");
  a_cached_refuse: assert property (
    I_CPU_VALID && !I_CPU_UNCACHED && ca[31:29] != 3'h0 |=> O_CACHED_PCI_ERR && !O_PCI_REQ)
    else $error("cached pci access not refused");
  a_unmapped_quiet: assert property (
    O_UNMAPPED |-> !O_PCI_REQ && !O_DRAM_SEL && O_LED_CELL_SEL == 4'h0 && !O_FLASH_SEL && !O_ROM_SOCKET_SEL)
    else $error("unmapped access selected something");
  a_idle_quiet: assert property (
    !I_CPU_VALID |=> !O_PCI_REQ && !O_DRAM_SEL && !O_UNMAPPED)
    else $error("select without strobe");
  a_inbound_all: assert property (
    I_PCI_IN_VALID && I_PCI_IN_ADDR[31:28] == 4'h8 |=> O_LMEM_REQ && !O_LMEM_ISA_DMA
    && O_LMEM_ADDR == $past(I_PCI_IN_ADDR[27:0]))
    else $error("inbound 256M window wrong");
  a_inbound_isa: assert property (
    I_PCI_IN_VALID && I_PCI_IN_ADDR[31:23] == 9'h001 |=> O_LMEM_REQ && O_LMEM_ISA_DMA
    && O_LMEM_ADDR == $past(I_PCI_IN_ADDR[27:0]))
    else $error("inbound 8M window wrong");
endmodule

bind bad_decoder bad_decoder_properties chk_u (.*);

// ---- bad_cpu_model.sv ----
// Purpose: Processor bus initiator in front of the decoder
// Assumes: One strobe per request
// Notes: Idle lines toggle so stale values never match
`timescale 1ns/1ps

module bad_cpu_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [35:0] i_addr,
  input wire logic i_write,
  input wire logic i_cached,
  output logic o_valid = 1'b0,
  output logic [35:0] o_addr = 36'h0,
  output logic o_write = 1'b0,
  output logic o_uncached = 1'b1
);
  // ----------
  // Strobe and qualifiers
  // ----------
  always_ff @(posedge i_clk)
  begin
    o_valid <= i_go;
    o_addr <= i_go ? i_addr : ~o_addr;
    o_write <= i_go ? i_write : ~o_write;
    o_uncached <= i_go ? !i_cached : ~o_uncached;
  end
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the board address decoder
// Assumes: Fixed seed
// Notes: None
`timescale 1ns/1ps

module tb_top;
  import bad_pkg::*;
  // ----------
  // Signals
  // ----------
  logic I_REF_CLK = 1'b0, I_RESETN = 1'b0, I_BOOT_SOURCE_JUMPER = 1'b0, I_PCI_IN_VALID = 1'b0;
  logic [31:0] I_PCI_IN_ADDR = 32'h0;
  logic I_CPU_VALID, I_CPU_WRITE, I_CPU_UNCACHED;
  logic [35:0] I_CPU_ADDR;
  logic O_DRAM_SEL, O_ROM_SOCKET_SEL, O_FLASH_SEL, O_ROM_WRITE_EN, O_BRIDGE_REG_SEL, O_INTC_SEL;
  logic O_LOGIC_REV_SEL, O_BOARD_CFG0_SEL, O_BOARD_CFG1_SEL, O_DRAM_CFG_SEL, O_BOARD_REV_SEL;
  logic O_PCI_REQ, O_PCI_WRITE, O_ISA_SUBTRACTIVE, O_CACHED_PCI_ERR, O_UNMAPPED, O_LMEM_REQ, O_LMEM_ISA_DMA;
  logic [27:0] O_DRAM_ADDR, O_LMEM_ADDR;
  logic [19:0] O_ROM_ADDR;
  logic [3:0] O_LED_CELL_SEL, O_INTC_INDEX;
  bad_space_t O_PCI_SPACE;
  logic [31:0] O_PCI_ADDR;
  logic [15:0] O_PCI_CONFIG_DEVICE_SELECT;
  logic go = 1'b0, wr = 1'b0, cached = 1'b0;
  logic [35:0] ga = 36'h0;
  int err_count = 0, compares = 0;
  integer seed = 42;
  logic [31:0] dir [37] = '{32'h00000040, 32'h0ffffffc, 32'h10000000, 32'h107ffffc, 32'h10800000,
    32'h11000100, 32'h17fffffc, 32'h18000000, 32'h1d0003f8, 32'h1ee01804, 32'h1ee08000, 32'h1ef00010,
    32'h1ef10000, 32'h1f800100, 32'h1f900000, 32'h1fa00000, 32'h1f880000, 32'h1fc00000, 32'h1fc7fffc,
    32'h1fd00004, 32'h1fe00008, 32'h1feffffc, 32'h1ff20010, 32'h1ff20014, 32'h1ff20018, 32'h1ff2001c,
    32'h1ff90000, 32'h1ff90020, 32'h1ff90024, 32'h1ff9003c, 32'h1ffa0000, 32'h1ffb0000, 32'h1ffc0000,
    32'h1ffd0000, 32'h1ff00000, 32'h20000000, 32'hfffffffc};

  bad_decoder dut_u (.*);
  bad_cpu_model cpu_u (.i_clk(I_REF_CLK), .i_go(go), .i_addr(ga), .i_write(wr), .i_cached(cached),
    .o_valid(I_CPU_VALID), .o_addr(I_CPU_ADDR), .o_write(I_CPU_WRITE), .o_uncached(I_CPU_UNCACHED));

  always #5 I_REF_CLK = ~I_REF_CLK;

  // ----------
  // Expectations
  // ----------
  function automatic logic is_pci(input logic [31:0] a);
    return a >= 32'h2000_0000 || a[31:23] == 9'h020 || (a >= 32'h1100_0000 && a < 32'h1800_0000)
      || a[31:24] == 8'h1d || (a[31:20] == 12'h1ee && a[19:15] == 5'h0);
  endfunction

  function automatic logic [15:0] exp_sel(input logic [31:0] a, input logic w, input logic u, input logic j);
    logic [1:0] k = a[21:20];
    if (a < 32'h1000_0000) return 16'h8000;
    if (is_pci(a)) return !u ? 16'h0002 : (a[31:23] == 9'h020 ? 16'h000c : 16'h0008);
    if (a[31:16] == 16'h1ef0) return 16'h0800;
    if (a[31:23] == 9'h03f && k != 2'h3 && (k == 2'h2 || !a[19]))
      return ((k == 2'h1 || (k == 2'h0 && !j)) ? 16'h4000 : 16'h2000) | ((w && !a[22]) ? 16'h1000 : 16'h0);
    if (a[31:4] == 28'h1ff2001) return 16'h0400;
    if (a[31:8] == 24'h1ff900 && a[7:2] < 6'd9) return 16'h0200;
    case (a)
      32'h1ff9_003c: return 16'h0100;
      32'h1ffa_0000: return 16'h0080;
      32'h1ffb_0000: return 16'h0040;
      32'h1ffc_0000: return 16'h0020;
      32'h1ffd_0000: return 16'h0010;
      default: return 16'h0001;
    endcase
  endfunction

  function automatic logic [31:0] exp_pa(input logic [31:0] a);
    if (a[31:24] == 8'h1d) return {8'h0, a[23:0]};
    if (a[31:20] == 12'h1ee) return (32'h1 << (16 + a[14:11])) | {21'h0, a[10:0]};
    return a >= 32'h2000_0000 ? a : a - 32'h1000_0000;
  endfunction

  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [31:0] a, input logic w, input logic c);
    logic [15:0] s;
    logic [31:0] pa = exp_pa(a);
    @(posedge I_REF_CLK);
    go <= 1'b1;
    ga <= {4'($random(seed)), a};
    wr <= w;
    cached <= c;
    @(posedge I_REF_CLK);
    go <= 1'b0;
    @(posedge I_REF_CLK);
    @(negedge I_REF_CLK);
    s = exp_sel(a, w, !c, I_BOOT_SOURCE_JUMPER);
    chk(32'({O_DRAM_SEL, O_ROM_SOCKET_SEL, O_FLASH_SEL, O_ROM_WRITE_EN, O_BRIDGE_REG_SEL, |O_LED_CELL_SEL,
      O_INTC_SEL, O_LOGIC_REV_SEL, O_BOARD_CFG0_SEL, O_BOARD_CFG1_SEL, O_DRAM_CFG_SEL, O_BOARD_REV_SEL,
      O_PCI_REQ, O_ISA_SUBTRACTIVE, O_CACHED_PCI_ERR, O_UNMAPPED}), 32'(s));
    if (s[3])
    begin
      chk(O_PCI_ADDR, pa);
      chk(32'(O_PCI_SPACE), 32'(a[31:24] == 8'h1d ? BAD_SP_IO : a[31:20] == 12'h1ee ? BAD_SP_CFG : BAD_SP_MEM));
      chk(32'(O_PCI_CONFIG_DEVICE_SELECT), 32'(pa[31:16]));
      chk(32'(O_PCI_WRITE), 32'(w));
    end
    if (s[15]) chk(32'(O_DRAM_ADDR), 32'(a[27:0]));
    if (s[14] || s[13]) chk(32'(O_ROM_ADDR), 32'(a[19:0]));
    if (s[10]) chk(32'(O_LED_CELL_SEL), 32'(4'h1 << a[3:2]));
    if (s[9]) chk(32'(O_INTC_INDEX), 32'(a[5:2]));
  endtask

  task automatic pin(input logic [31:0] a);
    logic isa = a[31:23] == 9'h001;
    logic hit = isa || a[31:28] == 4'h8;
    @(posedge I_REF_CLK);
    I_PCI_IN_VALID <= 1'b1;
    I_PCI_IN_ADDR <= a;
    @(posedge I_REF_CLK);
    I_PCI_IN_VALID <= 1'b0;
    I_PCI_IN_ADDR <= ~a;
    @(negedge I_REF_CLK);
    chk(32'({O_LMEM_REQ, O_LMEM_ISA_DMA}), 32'({hit, isa}));
    if (hit) chk(32'(O_LMEM_ADDR), 32'(a[27:0]));
  endtask

  task automatic end_sim;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------
  // Sequence
  // ----------
  initial
  begin
    repeat (20000) @(posedge I_REF_CLK);
    err_count++;
    end_sim();
  end

  initial
  begin
    logic [31:0] a;
    repeat (10) @(posedge I_REF_CLK);
    I_RESETN <= 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      @(posedge I_REF_CLK);
      I_BOOT_SOURCE_JUMPER <= j[0];
      foreach (dir[i]) op(dir[i], 1'($random(seed)), 1'b0);
    end
    op(32'h1100_0000, 1'b0, 1'b1);
    op(32'h3000_0000, 1'b1, 1'b1);
    foreach (dir[i]) pin(32'h0080_0010 + {dir[i][31:28], 28'h0});
    pin(32'h00ff_fffc);
    pin(32'h8fff_fffc);
    pin(32'h9000_0000);
    for (int i = 0; i < 200; i++)
    begin
      a = $random(seed);
      a[1:0] = 2'h0;
      if (i[0]) a[31:29] = 3'h0;
      op(a, 1'($random(seed)), ($random(seed) & 7) == 0);
    end
    repeat (300)
    begin
      @(posedge I_REF_CLK);
      go <= 1'b1;
      ga <= {4'($random(seed)), 32'($random(seed))};
      wr <= 1'($random(seed));
      cached <= 1'($random(seed));
      I_PCI_IN_VALID <= 1'($random(seed));
      I_PCI_IN_ADDR <= {4'($random(seed)) & 4'h8, 4'h0, 24'($random(seed))};
    end
    @(posedge I_REF_CLK);
    go <= 1'b0;
    I_PCI_IN_VALID <= 1'b0;
    I_RESETN <= 1'b0;
    repeat (3) @(posedge I_REF_CLK);
    I_RESETN <= 1'b1;
    op(32'h1fc0_0040, 1'b0, 1'b0);
    end_sim();
  end
endmodule
